// File: common/eepw_pkg.sv
// Constants and types for the EEPROM page-write host controller
package eepw_pkg;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned DIE_W = 4;
  localparam int unsigned PAGE_MAX = 128;
  // Timings in their own units
  localparam int unsigned STROBE_NS = 200;
  localparam int unsigned SETUP_NS = 100;
  localparam int unsigned LOAD_WIN_US = 30;
  localparam int unsigned IDLE_US = 100;
  localparam int unsigned WP_HOLD_MS = 10;
  localparam int unsigned WC_MS = 10;
  localparam int unsigned GLITCH_NS = 20;
  // Cycle counts: minima round up
  localparam int unsigned STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  // Maximum window rounds down
  localparam int unsigned LOAD_WIN_CYC = LOAD_WIN_US * CLK_MHZ;
  // Idle cycles left once hold, setup and strobe of the next byte are paid
  localparam int unsigned LOAD_WIN_LEFT =
    LOAD_WIN_CYC - 2 * SETUP_CYC - STROBE_CYC - 2;
  localparam int unsigned IDLE_CYC = IDLE_US * CLK_MHZ;
  localparam int unsigned WP_HOLD_CYC = WP_HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned WC_CYC = WC_MS * 1000 * CLK_MHZ;
  localparam int unsigned GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 24;
  // Command sequence addresses and data
  localparam logic [14:0] CMD_A1 = 15'h5555;
  localparam logic [14:0] CMD_A2 = 15'h2AAA;
  localparam logic [7:0] CMD_D_AA = 8'hAA;
  localparam logic [7:0] CMD_D_55 = 8'h55;
  localparam logic [7:0] CMD_D_A0 = 8'hA0;
  localparam logic [7:0] CMD_D_80 = 8'h80;
  localparam logic [7:0] CMD_D_20 = 8'h20;
  localparam int unsigned TOP_BIT = 7;
  localparam int unsigned DIE_LSB = 17;
  typedef enum logic [1:0] {
    EEPW_OP_WRITE,
    EEPW_OP_PROT_ON,
    EEPW_OP_PROT_OFF
  } eepw_op_t;
endpackage

// File: hdl/eepw_host.sv
// Host controller driving one EEPROM module through its strobes
`timescale 1ns/1ps
module eepw_host (
  input wire logic clock,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [18:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  output logic cmd_ready,
  output logic done,
  output logic timeout,
  output logic [18:0] addr,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic [7:0] data_in,
  output logic [3:0] die_select_n,
  output logic write_n,
  output logic read_n,
  output logic write_protect_hold_n,
  input wire logic ready_busy_n
);
  typedef enum logic [3:0] {
    S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_WAIT, S_POLL_SET, S_POLL,
    S_PROT_HOLD, S_DONE
  } eepw_state_t;

  typedef struct packed {
    eepw_state_t st;
    logic [23:0] cnt;
    logic [23:0] win;
    logic [2:0] seq;
    logic [2:0] seq_len;
    logic [1:0] op;
    logic [18:0] user_addr;
    logic [7:0] user_data;
    logic user_last;
    logic [7:0] last_byte;
    logic cmd_ready;
    logic done;
    logic timeout;
    logic [18:0] addr;
    logic [7:0] data_out;
    logic data_oe_n;
    logic [3:0] die_n;
    logic write_n;
    logic read_n;
    logic wp_n;
  } eepw_host_st_t;

  eepw_host_st_t s_r;
  eepw_host_st_t s_nxt;

  // Prefix address and data for step k of a command sequence
  function automatic logic [14:0] seq_addr(input logic [2:0] k);
    seq_addr = (k == 3'd1 || k == 3'd4) ? eepw_pkg::CMD_A2 : eepw_pkg::CMD_A1;
  endfunction

  function automatic logic [7:0] seq_data(input logic [2:0] k,
                                          input logic [1:0] op);
    case (k)
      3'd0, 3'd3: seq_data = eepw_pkg::CMD_D_AA;
      3'd1, 3'd4: seq_data = eepw_pkg::CMD_D_55;
      3'd2: seq_data = (op == 2'(eepw_pkg::EEPW_OP_PROT_OFF)) ?
                       eepw_pkg::CMD_D_80 : eepw_pkg::CMD_D_A0;
      default: seq_data = eepw_pkg::CMD_D_20;
    endcase
  endfunction

  function automatic logic [3:0] die_dec(input logic [18:0] a);
    die_dec = ~(4'h1 << a[18:eepw_pkg::DIE_LSB]);
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.timeout = 1'b0;
    s_nxt.wp_n = 1'b1;
    case (s_r.st)
      S_IDLE: begin
        s_nxt.cmd_ready = 1'b1;
        s_nxt.die_n = '1;
        s_nxt.write_n = 1'b1;
        s_nxt.read_n = 1'b1;
        s_nxt.data_oe_n = 1'b1;
        if (cmd_valid && s_r.cmd_ready) begin
          s_nxt.cmd_ready = 1'b0;
          s_nxt.op = cmd_op;
          s_nxt.user_addr = cmd_addr;
          s_nxt.user_data = cmd_data;
          s_nxt.user_last = cmd_last;
          s_nxt.seq = '0;
          // The first byte of each page is prefixed so it also lands in protected mode
          case (cmd_op)
            2'(eepw_pkg::EEPW_OP_PROT_OFF): s_nxt.seq_len = 3'd6;
            default: s_nxt.seq_len = (s_r.win != '0) ? 3'd0 : 3'd3;
          endcase
          s_nxt.cnt = '0;
          s_nxt.st = S_SETUP;
        end else if (s_r.win != '0) begin
          s_nxt.win = s_r.win - 24'd1;
          if (s_r.win == 24'd1) begin
            // Page closed by silence; strobes still owe the idle time
            s_nxt.cmd_ready = 1'b0;
            s_nxt.st = S_WAIT;
            s_nxt.cnt = '0;
          end
        end
      end
      S_SETUP: begin
        // Address settles and die is selected before the write strobe
        if (s_r.seq < s_r.seq_len) begin
          s_nxt.addr = {s_r.user_addr[18:15], seq_addr(s_r.seq)};
          s_nxt.data_out = seq_data(s_r.seq, s_r.op);
        end else begin
          s_nxt.addr = s_r.user_addr;
          s_nxt.data_out = s_r.user_data;
          s_nxt.last_byte = s_r.user_data;
        end
        s_nxt.die_n = die_dec(s_r.user_addr);
        s_nxt.data_oe_n = 1'b0;
        s_nxt.cnt = s_r.cnt + 24'd1;
        if (s_r.cnt == 24'(eepw_pkg::SETUP_CYC)) begin
          s_nxt.cnt = '0;
          s_nxt.write_n = 1'b0;
          s_nxt.st = S_STROBE;
        end
      end
      S_STROBE: begin
        // Pulse well beyond the glitch filter width
        s_nxt.cnt = s_r.cnt + 24'd1;
        if (s_r.cnt == 24'(eepw_pkg::STROBE_CYC)) begin
          s_nxt.cnt = '0;
          s_nxt.write_n = 1'b1;
          s_nxt.st = S_HOLD;
        end
      end
      S_HOLD: begin
        s_nxt.die_n = '1;
        s_nxt.data_oe_n = 1'b1;
        s_nxt.cnt = s_r.cnt + 24'd1;
        if (s_r.cnt == 24'(eepw_pkg::SETUP_CYC)) begin
          s_nxt.cnt = '0;
          // A cancel ends with its sixth step and carries no data byte
          if (s_r.seq + 3'd1 < s_r.seq_len ||
              (s_r.seq < s_r.seq_len &&
               s_r.op != 2'(eepw_pkg::EEPW_OP_PROT_OFF))) begin
            s_nxt.seq = s_r.seq + 3'd1;
            s_nxt.st = S_SETUP;
          end else if (s_r.op == 2'(eepw_pkg::EEPW_OP_WRITE) &&
                       !s_r.user_last) begin
            // Next byte must come within the load window
            s_nxt.win = 24'(eepw_pkg::LOAD_WIN_LEFT);
            s_nxt.cmd_ready = 1'b1;
            s_nxt.st = S_IDLE;
          end else begin
            s_nxt.win = '0;
            s_nxt.st = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        // Strobes idle so the device starts programming by itself
        s_nxt.cnt = s_r.cnt + 24'd1;
        if (s_r.cnt == 24'(eepw_pkg::IDLE_CYC)) begin
          s_nxt.cnt = '0;
          s_nxt.st = S_POLL_SET;
        end
      end
      S_POLL_SET: begin
        s_nxt.win = '0;
        s_nxt.die_n = die_dec(s_r.user_addr);
        s_nxt.read_n = 1'b0;
        s_nxt.data_oe_n = 1'b1;
        s_nxt.st = S_POLL;
      end
      S_POLL: begin
        s_nxt.cnt = s_r.cnt + 24'd1;
        // Both indicators must agree; a cancel loads no byte to poll
        if ((s_r.op == 2'(eepw_pkg::EEPW_OP_PROT_OFF) ||
             data_in[eepw_pkg::TOP_BIT] ==
             s_r.last_byte[eepw_pkg::TOP_BIT]) &&
            ready_busy_n) begin
          s_nxt.read_n = 1'b1;
          s_nxt.die_n = '1;
          s_nxt.cnt = '0;
          s_nxt.st = S_PROT_HOLD;
        end else if (s_r.cnt == 24'(eepw_pkg::WC_CYC)) begin
          s_nxt.timeout = 1'b1;
          s_nxt.read_n = 1'b1;
          s_nxt.die_n = '1;
          s_nxt.cnt = '0;
          s_nxt.st = S_PROT_HOLD;
        end
      end
      S_PROT_HOLD: begin
        // Polling may end early; the hold pin stays high anyway
        s_nxt.cnt = s_r.cnt + 24'd1;
        if (s_r.cnt == 24'(eepw_pkg::WP_HOLD_CYC)) begin
          s_nxt.st = S_DONE;
        end
      end
      S_DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.cmd_ready = 1'b1;
        s_nxt.cnt = '0;
        s_nxt.st = S_IDLE;
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.st <= S_IDLE;
      s_r.die_n <= '1;
      s_r.write_n <= 1'b1;
      s_r.read_n <= 1'b1;
      s_r.data_oe_n <= 1'b1;
      s_r.wp_n <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cmd_ready = s_r.cmd_ready;
  assign done = s_r.done;
  assign timeout = s_r.timeout;
  assign addr = s_r.addr;
  assign data_out = s_r.data_out;
  assign data_oe_n = s_r.data_oe_n;
  assign die_select_n = s_r.die_n;
  assign write_n = s_r.write_n;
  assign read_n = s_r.read_n;
  assign write_protect_hold_n = s_r.wp_n;

  int unsigned onehot_c;
  always_comb onehot_c = $countones(~s_r.die_n);

  one_die_a: assert property (@(posedge clock) disable iff (!nrst)
    onehot_c <= 1) else $error("more than one die selected");

  sequence wr_pulse_s;
    !write_n [*5];
  endsequence

  strobe_width_a: assert property (@(posedge clock) disable iff (!nrst)
    $fell(write_n) |-> wr_pulse_s) else $error("write strobe too short");

  strobe_sel_a: assert property (@(posedge clock) disable iff (!nrst)
    !write_n |-> die_select_n != '1) else $error("strobe without die");

  wp_high_a: assert property (@(posedge clock) disable iff (!nrst)
    (!write_n || !read_n) |-> write_protect_hold_n)
    else $error("hold pin low during access");

  no_rw_a: assert property (@(posedge clock) disable iff (!nrst)
    !(!write_n && !read_n)) else $error("read and write together");

  data_stable_a: assert property (@(posedge clock) disable iff (!nrst)
    !write_n && !$fell(write_n) |-> $stable(data_out))
    else $error("data moved under strobe");

  idle_go_a: assert property (@(posedge clock) disable iff (!nrst)
    s_r.st == S_WAIT |-> write_n && read_n)
    else $error("strobe during idle wait");

  done_pulse_a: assert property (@(posedge clock) disable iff (!nrst)
    done |-> cmd_ready ##1 !done) else $error("done not a single pulse");
endmodule

// File: tb/eepw_dev_model.sv
// Behavioural model of the four-die EEPROM module seen by the host
`timescale 1ns/1ps
module eepw_dev_model #(
  parameter int WC_NS = 200000
) (
  input wire logic [18:0] addr,
  input wire logic [7:0] data_w,
  input wire logic [3:0] die_select_n,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic write_protect_hold_n,
  output logic [7:0] data_q,
  output logic data_drive,
  output logic ready_busy_n
);
  logic [7:0] mem [int];
  logic [7:0] pg [int];
  logic [7:0] last = 8'hFF;
  logic [18:0] a_lat;
  logic [11:0] base;
  logic prot = 0, busy = 0, loading = 0, abort = 0;
  int seq = 0, late = 0;
  realtime t_fall, t_load;
  wire sel = ~&die_select_n;
  wire strobe = write_n | ~sel;

  function automatic logic [1:0] die();
    for (int i = 0; i < 4; i++) if (!die_select_n[i]) return 2'(i);
    return 2'h0;
  endfunction

  task automatic load(logic [7:0] d);
    pg[a_lat[6:0]] = d;
    base = a_lat[18:7];
    last = d;
    // A byte later than the load window counts against the host
    if (loading && $realtime - t_load > 30000.0) late++;
    t_load = $realtime;
    loading = 1;
  endtask

  task automatic take(logic [7:0] d);
    logic c1, c2, ok;
    c1 = a_lat[14:0] == 15'h5555;
    c2 = a_lat[14:0] == 15'h2AAA;
    case (seq)
      1, 5: ok = c2 && d == 8'h55;
      2: ok = c1 && (d == 8'hA0 || d == 8'h80);
      6: ok = c1 && d == 8'h20;
      default: ok = c1 && d == 8'hAA;
    endcase
    if (seq == 3) load(d);
    else if (ok) begin
      // Command bytes never reach the page buffer
      seq = (seq == 2 && d == 8'h80) ? 4 : seq + 1;
      prot = (seq == 3) ? 1'b1 : (seq == 7) ? 1'b0 : prot;
      if (seq == 7) seq = 0;
    end else begin
      seq = (c1 && d == 8'hAA) ? 1 : 0;
      if (!prot && seq == 0) load(d);
    end
  endtask

  always @(negedge strobe) begin
    a_lat = {die(), addr[16:0]};
    t_fall = $realtime;
  end
  // Short strobes are noise and never latch a byte
  always @(posedge strobe)
    if (write_protect_hold_n && !busy && $realtime - t_fall > 20.0)
      take(data_w);

  always begin
    #1000;
    if (loading && !busy && strobe && $realtime - t_load >= 100000.0) begin
      busy = 1;
      abort = 0;
      #WC_NS;
      if (!abort) foreach (pg[i]) mem[{base, i[6:0]}] = pg[i];
      pg.delete();
      seq = 0;
      busy = 0;
      loading = 0;
    end
  end
  always @(negedge write_protect_hold_n) abort = busy;

  assign ready_busy_n = ~(busy | loading);
  assign data_drive = sel && !read_n && write_n && write_protect_hold_n;
  always @(addr or busy or read_n or die_select_n) begin
    data_q = mem.exists({die(), addr[16:0]}) ? mem[{die(), addr[16:0]}] : 8'hFF;
    if (busy) data_q[7] = ~last[7];
  end
endmodule

// File: tb/eepw_host_bench.sv
// Self-checking bench for the EEPROM page-write host controller
`timescale 1ns/1ps
module eepw_host_bench;
  logic clock = 0, nrst = 0, cmd_valid = 0, cmd_last = 0;
  logic [1:0] cmd_op = 2'h0;
  logic [18:0] cmd_addr = 19'h0_0000;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, data_oe_n, write_n, read_n, wp_n, rb_n, drv, done, timeout;
  logic [18:0] addr;
  logic [7:0] data_out, data_in, dev_q;
  logic [3:0] die_select_n;
  logic [7:0] exp_mem [int];
  int bad_count = 0, samples_checked = 0, cycles = 0;
  int sizes [3] = '{128, 1, 5};
  logic [31:0] lfsr = 32'h6006;

  always #20 clock = ~clock;
  assign data_in = drv ? dev_q : ~data_out;

  eepw_host eepw_host_i (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_last(cmd_last), .cmd_ready(cmd_ready), .done(done),
    .timeout(timeout),
    .addr(addr), .data_out(data_out), .data_oe_n(data_oe_n),
    .data_in(data_in), .die_select_n(die_select_n), .write_n(write_n),
    .read_n(read_n), .write_protect_hold_n(wp_n), .ready_busy_n(rb_n));
  eepw_dev_model eepw_dev_model_i (.addr(addr), .data_w(data_out),
    .die_select_n(die_select_n), .write_n(write_n), .read_n(read_n),
    .write_protect_hold_n(wp_n), .data_q(dev_q), .data_drive(drv),
    .ready_busy_n(rb_n));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 70000) begin
      bad_count++;
      results();
    end
  end
  always @(negedge write_n or negedge read_n) begin
    check("hold pin", wp_n, 1'b1);
    check("selects", $countones(~die_select_n), 1);
    check("bus drive", data_oe_n, write_n);
  end

  task automatic do_reset();
    @(negedge clock);
    nrst = 0;
    repeat (4) @(negedge clock);
    check("hold pin", wp_n, 1'b0);
    nrst = 1;
    repeat (3) @(negedge clock);
    check("ready", cmd_ready, 1'b1);
    check("hold pin", wp_n, 1'b1);
  endtask

  task automatic send(logic [1:0] op, logic [18:0] a, logic [7:0] d, bit l);
    int n = 0;
    @(negedge clock);
    cmd_valid = 1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_last = l;
    // Seen high at a falling edge, so the coming rising edge takes it
    while (!cmd_ready && n++ < 3000) @(negedge clock);
    @(negedge clock);
    cmd_valid = 0;
  endtask

  task automatic wait_busy(logic v);
    for (int n = 0; eepw_dev_model_i.busy !== v && n < 9000; n++)
      @(negedge clock);
  endtask

  task automatic cmp_page(logic [18:0] a);
    int k;
    for (int i = 0; i < 128; i++) begin
      k = {a[18:7], i[6:0]};
      check("array byte", eepw_dev_model_i.mem.exists(k) ?
        eepw_dev_model_i.mem[k] : 8'hFF,
        exp_mem.exists(k) ? exp_mem[k] : 8'hFF);
    end
  endtask

  task automatic page(logic [1:0] op, logic [18:0] a, int n, bit keep);
    logic [18:0] k;
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      k = a;
      k[6:0] = a[6:0] + 7'(i * 37);
      d = 8'(rnd());
      if (keep) exp_mem[k] = d;
      send(op, k, d, i == n - 1);
    end
    wait_busy(1'b1);
    check("busy line", rb_n, 1'b0);
    // Reset drops the hold pin and must kill the running program
    if (!keep) do_reset();
    wait_busy(1'b0);
    check("busy line", rb_n, 1'b1);
    repeat (2) @(negedge clock);
    check("poll end", read_n, 1'b1);
    check("done", done, 1'b0);
    check("timeout", timeout, 1'b0);
    check("window", eepw_dev_model_i.late, 0);
    cmp_page(a);
    if (keep) do_reset();
    $display("page test op %0d of %0d bytes done", op, n);
  endtask

  initial begin
    logic [18:0] a;
    do_reset();
    foreach (sizes[s]) page(2'h0, 19'(rnd()), sizes[s], 1'b1);
    a = 19'(rnd());
    page(2'h1, a, 1, 1'b1);
    check("protect", eepw_dev_model_i.prot, 1'b1);
    page(2'h0, a, 3, 1'b1);
    send(2'h2, a, 8'h00, 1'b1);
    for (int n = 0; eepw_dev_model_i.prot && n < 5000; n++) @(negedge clock);
    check("protect", eepw_dev_model_i.prot, 1'b0);
    cmp_page({a[18:15], 15'h5555});
    for (int n = 0; read_n && n < 4000; n++) @(negedge clock);
    @(negedge clock);
    check("cancel poll", read_n, 1'b1);
    check("cancel load", eepw_dev_model_i.loading, 1'b0);
    do_reset();
    $display("cancel test done");
    page(2'h0, 19'(rnd()), 4, 1'b0);
    results();
  end
endmodule
